/* File: ttl_in_map.svh */
`ifndef TTL_IN_MAP_SVH
`define TTL_IN_MAP_SVH

`define TTL_IN_WIDTH 8
`define TTL_IN_SYNC_STAGES 2
`define TTL_IN_RESET_VALUE 8'hff
`define TTL_IN_HOLD_RESET 1'h1

`endif

/* File: ttl_in_pkg.sv */
package ttl_in_pkg;
    `include "ttl_in_map.svh"

    typedef logic [`TTL_IN_WIDTH-1:0] line_word_t;

    typedef enum logic {
        MODE_BUFFERED,
        MODE_LATCHED
    } port_mode_e;
endpackage : ttl_in_pkg

/* File: line_sync.sv */
`timescale 1ns/10ps
module line_sync
    import ttl_in_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // first stage is read only by the second
    generate
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    stage1_q[i] <= RESET_VALUE[i];
                    stage2_q[i] <= RESET_VALUE[i];
                end
                else
                begin
                    stage1_q[i] <= async_in[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2_q;
endmodule : line_sync

/* File: ttl_input_port_latch.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - eight input lines, high reads one
// - line one is lsb, binary weighted
// - unsigned 8-bit value, codes 0 to 255
// - floating line reads high, as pulled up
// - hold high or open: live levels read
`include "ttl_in_map.svh"

module ttl_input_port_latch
    import ttl_in_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins from the apparatus
    input wire logic [`TTL_IN_WIDTH-1:0] line_in,
    input wire logic hold_n,
    // value seen by the host
    output logic [`TTL_IN_WIDTH-1:0] port_value,
    output logic latched_mode
);
    // hold pin rides above the eight lines in one synchroniser word
    localparam int SYNC_WIDTH = `TTL_IN_WIDTH + 1;
    localparam int HOLD_BIT = `TTL_IN_WIDTH;

    typedef logic [SYNC_WIDTH-1:0] sync_word_t;

    // pad pull-ups are outside; reset values match an open line
    localparam line_word_t RESET_WORD = `TTL_IN_RESET_VALUE;
    localparam sync_word_t SYNC_RESET = {`TTL_IN_HOLD_RESET, `TTL_IN_RESET_VALUE};

    // pins before and after the synchroniser
    wire sync_word_t pins_raw;
    sync_word_t pins_sync;
    wire line_word_t lines_sync;
    logic hold_n_sync;

    // hold edge detection
    logic hold_n_prev_q;
    logic hold_fall;

    // mode state
    port_mode_e mode_q;
    port_mode_e mode_d;

    // captured word and output flops
    line_word_t held_q;
    line_word_t port_value_q;
    logic latched_mode_q;

    // one-cycle strobe when a level drops
    function automatic logic fell_edge(
        input logic prev_level,
        input logic now_level
    );
        fell_edge = prev_level && !now_level;
    endfunction : fell_edge

    // true for the mode that shows the captured word
    function automatic logic is_latched(
        input port_mode_e mode
    );
        case (mode)
            MODE_LATCHED:
                is_latched = 1'h1;
            default:
                is_latched = 1'h0;
        endcase
    endfunction : is_latched

    // bit the host sees in a given mode
    function automatic logic pick_bit(
        input port_mode_e mode,
        input logic live_bit,
        input logic held_bit
    );
        case (mode)
            MODE_BUFFERED:
                pick_bit = live_bit;
            MODE_LATCHED:
                pick_bit = held_bit;
            default:
                pick_bit = live_bit;
        endcase
    endfunction : pick_bit

    // line n of the connector is bit n-1 of the word
    generate
        for (genvar n = 0; n < `TTL_IN_WIDTH; n++)
        begin : g_pack
            assign pins_raw[n] = line_in[n];
            assign lines_sync[n] = pins_sync[n];
        end
    endgenerate

    assign pins_raw[HOLD_BIT] = hold_n;
    assign hold_n_sync = pins_sync[HOLD_BIT];

    // every pin, hold included, gets the same two stages so skew is equal
    line_sync #(
        .WIDTH(SYNC_WIDTH),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // idle level of the hold pin, so no false edge after reset
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            hold_n_prev_q <= `TTL_IN_HOLD_RESET;
        end
        else
        begin
            hold_n_prev_q <= hold_n_sync;
        end
    end

    // a hold pulse shorter than a clock period can be missed
    always_comb
    begin
        hold_fall = fell_edge(hold_n_prev_q, hold_n_sync);
    end

    // leaves latched mode only once hold is high again
    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            MODE_BUFFERED:
            begin
                if (hold_fall)
                begin
                    mode_d = MODE_LATCHED;
                end
            end
            MODE_LATCHED:
            begin
                if (hold_n_sync)
                begin
                    mode_d = MODE_BUFFERED;
                end
            end
            default:
            begin
                mode_d = MODE_BUFFERED;
            end
        endcase
    end

    // mode register
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mode_q <= MODE_BUFFERED;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // mirrors the mode in its own flop so the pin carries no decode
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            latched_mode_q <= 1'h0;
        end
        else
        begin
            latched_mode_q <= is_latched(mode_d);
        end
    end

    generate
        for (genvar n = 0; n < `TTL_IN_WIDTH; n++)
        begin : g_line
            // capture on the synchronised falling edge of hold
            // lines must be steady when hold falls, as lines and hold pass the same two stages
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    held_q[n] <= RESET_WORD[n];
                end
                else if (hold_fall)
                begin
                    held_q[n] <= lines_sync[n];
                end
            end

            // unchanged bit position gives the binary weighting for free
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    port_value_q[n] <= RESET_WORD[n];
                end
                else
                begin
                    port_value_q[n] <= pick_bit(mode_q, lines_sync[n], held_q[n]);
                end
            end
        end
    endgenerate

    // full eight-bit word, no sign: every code 0 to 255 reaches the host
    assign port_value = port_value_q;
    assign latched_mode = latched_mode_q;
endmodule : ttl_input_port_latch

/* File: apparatus_model.sv */
`timescale 1ns/10ps
module apparatus_model (
    // levels and drive enables, hold pin on bit 8
    input wire logic [8:0] level,
    input wire logic [8:0] drive,
    // pins towards the port
    output logic [7:0] line_in,
    output logic hold_n
);
    // bit 8 is the hold pin; an undriven pin floats high
    assign {hold_n, line_in} = level | ~drive;
endmodule : apparatus_model

/* File: ttl_in_sva.sv */
`timescale 1ns/10ps
`include "ttl_in_map.svh"
module ttl_in_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins from the apparatus
    input wire logic [`TTL_IN_WIDTH-1:0] line_in,
    input wire logic hold_n,
    // value seen by the host
    input wire logic [`TTL_IN_WIDTH-1:0] port_value,
    input wire logic latched_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_held_value: assert property (latched_mode[*3] |-> $stable(port_value))
        else $error("held value moved");
    a_hold_entry: assert property ($fell(hold_n) ##1 !hold_n[*2] |=> latched_mode)
        else $error("hold not taken");
    a_hold_exit: assert property ($rose(hold_n) ##1 hold_n[*2] |=> !latched_mode)
        else $error("hold release not taken");
    a_live_follow: assert property (
        !latched_mode && !$past(reset) && !$past(reset, 2) |=> port_value == $past(line_in, 3))
        else $error("live value wrong");
    a_latch_capture: assert property (
        $fell(hold_n) ##1 !hold_n[*3] |=> port_value == $past(line_in, 4))
        else $error("captured value wrong");
    a_latch_cause: assert property ($rose(latched_mode) |-> !$past(hold_n, 3))
        else $error("latched without hold");
    a_mode_exit: assert property (
        $fell(latched_mode) && !$past(reset) |-> $past(hold_n, 3))
        else $error("left latched while hold low");
    a_reset_state: assert property (
        disable iff (1'h0) reset |=> port_value == `TTL_IN_RESET_VALUE && !latched_mode)
        else $error("reset state wrong");
endmodule : ttl_in_sva
bind ttl_input_port_latch ttl_in_sva sva_u (
    .core_clk(core_clk),
    .reset(reset),
    .line_in(line_in),
    .hold_n(hold_n),
    .port_value(port_value),
    .latched_mode(latched_mode)
);

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic core_clk = 0, reset = 1;
    logic [8:0] level = 9'h0, drive = 9'h0ff;
    wire [7:0] line_in, port_value;
    wire hold_n, latched_mode;
    int failures = 0, compares = 0;
    always #50 core_clk = ~core_clk;
    apparatus_model far_u (
        .level(level),
        .drive(drive),
        .line_in(line_in),
        .hold_n(hold_n)
    );
    ttl_input_port_latch dut_u (
        .core_clk(core_clk),
        .reset(reset),
        .line_in(line_in),
        .hold_n(hold_n),
        .port_value(port_value),
        .latched_mode(latched_mode)
    );
    task automatic look(input logic [8:0] v, e, input int n);
        level = v;
        repeat (n) @(negedge core_clk);
        compares++;
        if ({latched_mode, port_value} !== e)
        begin
            failures++;
            $display("wrong value port exp %h got %h", e, {latched_mode, port_value});
        end
    endtask : look
    task automatic live_codes;
        for (int i = 0; i < 8; i++)
            look(9'h1 << i, 9'h1 << i, 4);
        look(9'h0ff, 9'h0ff, 4);
        look(9'h000, 9'h000, 4);
    endtask : live_codes
    task automatic hold_cycle;
        // a5 lines left open, so they must read high
        drive = 9'h15a;
        look(9'h100, 9'h0a5, 4);
        look(9'h000, 9'h1a5, 5);
        drive = 9'h1ff;
        look(9'h05a, 9'h1a5, 4);
        look(9'h15a, 9'h05a, 5);
    endtask : hold_cycle
    task automatic complete_run;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial
    begin
        look(9'h0, 9'h0ff, 16);
        reset = 0;
        live_codes();
        hold_cycle();
        complete_run();
    end
endmodule : testbench
